// ==== shared/prio_irq_pkg.sv ====
// Shared constants, timing figures and state types for the priority request logic
package prio_irq_pkg;

    // Core clock rate in MHz
    localparam int CLK_MHZ = 200;

    // Number of priority levels and width of the granted level code
    localparam int NUM_LEVELS = 32;
    localparam int CODE_W = 5;
    localparam int DESC_W = 8;

    // Printed times, in nanoseconds
    localparam int REQ_MIN_PULSE_NS = 500;
    localparam int CODE_SETUP_NS = 100;
    localparam int ACK_EXPECT_NS = 1000;
    localparam int STROBE_HOLD_NS = 2500;
    localparam int FAST_FETCH_NS = 5000;
    localparam int ACK_TO_FETCH_NS = 3000;
    localparam int TIMER_RES_NS = 13000;

    // Least times round up to whole cycles, never below one
    function automatic int ns_to_cyc_up(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    // Cycle counts derived from the times above
    localparam int REQ_MIN_PULSE_CYC = ns_to_cyc_up(REQ_MIN_PULSE_NS);
    localparam int CODE_SETUP_CYC = ns_to_cyc_up(CODE_SETUP_NS);
    localparam int ACK_EXPECT_CYC = ns_to_cyc_up(ACK_EXPECT_NS);
    localparam int STROBE_HOLD_CYC = ns_to_cyc_up(STROBE_HOLD_NS);
    localparam int FAST_FETCH_CYC = ns_to_cyc_up(FAST_FETCH_NS);
    localparam int ACK_TO_FETCH_CYC = ns_to_cyc_up(ACK_TO_FETCH_NS);
    localparam int TIMER_RES_CYC = ns_to_cyc_up(TIMER_RES_NS);

    // Counter width, enough for the longest count above
    localparam int CNT_W = 12;

    // Reset values
    localparam logic [NUM_LEVELS-1:0] MASK_RESET = 32'h0000_0000;
    localparam logic [31:0] TIMER_RESET = 32'h0000_0000;

    // Grant sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_FINISH
    } grant_state_e;

endpackage

// ==== rtl/request_edge_catcher.sv ====
// Two-stage synchroniser and rising-edge detector for the request pins
`timescale 1ns/100ps
`default_nettype none

module request_edge_catcher #(
    parameter int WIDTH = 32
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] line_i,
    output logic [WIDTH-1:0] rise_o
);
    import prio_irq_pkg::*;

    // Refuse an empty request bus at elaboration
    if (WIDTH < 1) begin : g_bad_width
        $error("request_edge_catcher: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
        logic [WIDTH-1:0] rise;
    } catch_s;

    catch_s cur;
    catch_s next_cur;

    // Only the second stage feeds the edge detector
    always_comb begin
        next_cur = cur;
        next_cur.meta = line_i;
        next_cur.sync = cur.meta;
        next_cur.prev = cur.sync;
        next_cur.rise = cur.sync & ~cur.prev;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign rise_o = cur.rise;

endmodule

`default_nettype wire

// ==== rtl/priority_interrupt_request_accept.sv ====
// Priority request latching, resolution and grant handshake with the external device
`timescale 1ns/100ps
`default_nettype none

module priority_interrupt_request_accept #(
    parameter int LEVELS = 32
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [LEVELS-1:0] request_i,
    input wire logic ack_i,
    input wire logic [prio_irq_pkg::DESC_W-1:0] desc_i,
    input wire logic instr_end_i,
    input wire logic timer_ref_i,
    input wire logic timer_present_i,
    input wire logic bg_req_i,
    input wire logic level_exit_i,
    input wire logic mask_update_i,
    input wire logic mask_or_i,
    input wire logic mask_cancel_i,
    input wire logic [LEVELS-1:0] mask_word_i,
    input wire logic timer_load_i,
    input wire logic [31:0] timer_load_word_i,
    output logic [prio_irq_pkg::CODE_W-1:0] grant_code_o,
    output logic strobe_o,
    output logic seq_stop_o,
    output logic psw_swap_o,
    output logic fetch_o,
    output logic bg_grant_o,
    output logic [prio_irq_pkg::DESC_W-1:0] desc_o,
    output logic [LEVELS-1:0] pending_o,
    output logic [LEVELS-1:0] active_o,
    output logic [LEVELS-1:0] mask_o,
    output logic [31:0] timer_word_o
);
    import prio_irq_pkg::*;

    // Refuse level counts that the five code lines cannot carry
    if (LEVELS < 2 || LEVELS > NUM_LEVELS) begin : g_bad_levels
        $error("priority_interrupt_request_accept: LEVELS must be 2 to 32");
    end

    // Lowest set bit as a one-hot vector
    function automatic logic [LEVELS-1:0] lowest_hot(input logic [LEVELS-1:0] v);
        return v & (~v + {{(LEVELS-1){1'b0}}, 1'b1});
    endfunction

    // Index of the lowest set bit, level 0 winning
    function automatic logic [CODE_W-1:0] lowest_idx(input logic [LEVELS-1:0] v);
        logic [CODE_W-1:0] idx;
        idx = '0;
        for (int i = LEVELS - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = CODE_W'(i);
            end
        end
        return idx;
    endfunction

    // Bit i set when any bit at or below i is set
    function automatic logic [LEVELS-1:0] prefix_or(input logic [LEVELS-1:0] v);
        logic [LEVELS-1:0] r;
        r = v;
        for (int i = 1; i < LEVELS; i++) begin
            r[i] = r[i] | r[i-1];
        end
        return r;
    endfunction

    typedef struct packed {
        grant_state_e st;
        logic [LEVELS-1:0] req;
        logic [LEVELS-1:0] act;
        logic [LEVELS-1:0] mask;
        logic [CODE_W-1:0] code;
        logic strobe;
        logic ack_meta;
        logic ack_sync;
        logic [DESC_W-1:0] desc_meta;
        logic [DESC_W-1:0] desc_sync;
        logic [DESC_W-1:0] desc;
        logic [CNT_W-1:0] elapsed;
        logic [CNT_W-1:0] since_ack;
        logic [CNT_W-1:0] phase;
        logic program_status_word;
        logic fetch;
        logic bg;
        logic [31:0] timer;
        logic [CNT_W-1:0] tdiv;
    } accept_s;

    accept_s cur;
    accept_s next_cur;
    logic [LEVELS-1:0] rise;
    logic [LEVELS-1:0] blocked;
    logic [LEVELS-1:0] qual;
    logic timer_defer;
    logic take;
    logic [LEVELS-1:0] grant_hot;

    request_edge_catcher #(
        .WIDTH(LEVELS)
    ) u_catch (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .line_i(request_i),
        .rise_o(rise)
    );

    // an active level blocks itself and all below it
    assign blocked = prefix_or(cur.act);
    // lower-level activity never hides a higher request
    assign qual = cur.req & cur.mask & ~blocked;
    // no acceptance at the end of a timer word reference
    assign timer_defer = timer_ref_i & timer_present_i;
    // boundary check, strobe may only rise with acknowledge low
    assign take = instr_end_i && (cur.st == ST_IDLE) && (|qual) && !cur.ack_sync && !timer_defer;
    assign grant_hot = lowest_hot(qual);

    always_comb begin
        next_cur = cur;
        next_cur.program_status_word = 1'b0;
        next_cur.fetch = 1'b0;
        next_cur.bg = 1'b0;

        // Acknowledge and descriptor pins pass two stages first
        next_cur.ack_meta = ack_i;
        next_cur.ack_sync = cur.ack_meta;
        next_cur.desc_meta = desc_i;
        next_cur.desc_sync = cur.desc_meta;

        // OR option adds levels, the plain update narrows by AND
        if (mask_update_i && mask_or_i) begin
            next_cur.mask = cur.mask | mask_word_i;
        end else if (mask_update_i && !mask_cancel_i) begin
            next_cur.mask = cur.mask & mask_word_i;
        end

        if (mask_update_i && mask_cancel_i) begin
            next_cur.req = next_cur.req & ~mask_word_i;
        end

        // Leaving a handler frees the highest active level
        if (level_exit_i) begin
            next_cur.act = cur.act & ~lowest_hot(cur.act);
        end

        // Elapsed time since the grant, saturating
        if (cur.st != ST_IDLE && cur.elapsed != CNT_W'(FAST_FETCH_CYC)) begin
            next_cur.elapsed = cur.elapsed + CNT_W'(1);
        end

        case (cur.st)
            ST_IDLE: begin
                if (take) begin
                    // code first, strobe after the setup time
                    next_cur.code = lowest_idx(qual);
                    next_cur.st = ST_SETUP;
                    next_cur.phase = '0;
                    next_cur.elapsed = '0;
                    next_cur.since_ack = '0;
                    // status word swap starts with the grant
                    next_cur.program_status_word = 1'b1;
                end else if (instr_end_i && bg_req_i && !timer_defer && cur.act == '0 && qual == '0) begin
                    // background only when no level runs or waits
                    next_cur.bg = 1'b1;
                end
            end
            ST_SETUP: begin
                next_cur.phase = cur.phase + CNT_W'(1);
                if (cur.phase == CNT_W'(CODE_SETUP_CYC - 1)) begin
                    next_cur.strobe = 1'b1;
                    next_cur.st = ST_STROBE;
                end
            end
            ST_STROBE: begin
                // strobe state waits as long as the acknowledge is late
                if (cur.ack_sync) begin
                    // handshake point clears the granted latch
                    next_cur.req[cur.code] = 1'b0;
                    next_cur.act[cur.code] = 1'b1;
                    next_cur.desc = cur.desc_sync;
                    next_cur.phase = '0;
                    next_cur.st = ST_HOLD;
                end
            end
            ST_HOLD: begin
                next_cur.phase = cur.phase + CNT_W'(1);
                // strobe falls while acknowledge is still high
                if (cur.phase == CNT_W'(STROBE_HOLD_CYC - 1)) begin
                    next_cur.strobe = 1'b0;
                    next_cur.st = ST_FINISH;
                end
            end
            ST_FINISH: begin
                // prompt acknowledge, fetch paced by the grant
                if (cur.elapsed == CNT_W'(FAST_FETCH_CYC) && cur.since_ack >= CNT_W'(ACK_TO_FETCH_CYC)) begin
                    next_cur.fetch = 1'b1;
                    next_cur.st = ST_IDLE;
                end
            end
            default: begin
                next_cur.st = ST_IDLE;
                next_cur.strobe = 1'b0;
            end
        endcase

        // time since the acknowledge rose, saturating
        if ((cur.st == ST_HOLD || cur.st == ST_FINISH) && cur.since_ack != CNT_W'(ACK_TO_FETCH_CYC)) begin
            next_cur.since_ack = cur.since_ack + CNT_W'(1);
        end

        // a detected edge sets its latch; set beats the handshake and cancel clears
        // an already set latch absorbs repeats
        // after the handshake clear a new edge sets it again
        next_cur.req = next_cur.req | rise;

        // timer word steps down once per resolution period
        if (cur.tdiv == CNT_W'(TIMER_RES_CYC - 1)) begin
            next_cur.tdiv = '0;
            next_cur.timer = cur.timer - 32'h0000_0001;
        end else begin
            next_cur.tdiv = cur.tdiv + CNT_W'(1);
        end
        if (timer_load_i) begin
            next_cur.timer = timer_load_word_i;
            next_cur.tdiv = '0;
        end
    end

    // only reset, the handshake or cancel clear a latch
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cur <= '0;
            cur.st <= ST_IDLE;
            cur.mask <= LEVELS'(MASK_RESET);
            cur.timer <= TIMER_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from state
    // code held from grant
    assign grant_code_o = cur.code;
    assign strobe_o = cur.strobe;
    assign seq_stop_o = (cur.st != ST_IDLE);
    assign psw_swap_o = cur.program_status_word;
    assign fetch_o = cur.fetch;
    assign bg_grant_o = cur.bg;
    assign desc_o = cur.desc;
    assign pending_o = cur.req;
    assign active_o = cur.act;
    assign mask_o = cur.mask;
    assign timer_word_o = cur.timer;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_grant;
        psw_swap_o;
    endsequence

    sequence s_prompt_ack;
        ##[1:190] $rose(cur.ack_sync);
    endsequence

    a_code_held_strobe: assert property (strobe_o && $past(strobe_o) |-> $stable(grant_code_o))
        else $error("grant code changed while strobe high");

    a_strobe_rise_ack: assert property ($rose(strobe_o) |-> !cur.ack_sync)
        else $error("strobe rose with acknowledge high");

    a_strobe_fall_ack: assert property ($fell(strobe_o) |-> cur.ack_sync)
        else $error("strobe fell with acknowledge low");

    a_strobe_after_setup: assert property (s_grant |-> !strobe_o [*8] ##[12:13] strobe_o)
        else $error("strobe not raised after code setup");

    a_latch_cleared: assert property (cur.st == ST_STROBE && cur.ack_sync && !rise[cur.code]
        |=> !pending_o[$past(grant_code_o)])
        else $error("granted latch not cleared at handshake");

    a_fast_fetch: assert property (s_grant ##0 s_prompt_ack |-> ##[1:1000] fetch_o)
        else $error("prompt acknowledge did not give fetch in time");

    a_fetch_not_early: assert property (fetch_o |-> $past(cur.elapsed) == CNT_W'(FAST_FETCH_CYC)
        && $past(cur.since_ack) >= CNT_W'(ACK_TO_FETCH_CYC))
        else $error("fetch came too early");

    a_take_on_qual: assert property (take |=> psw_swap_o && seq_stop_o)
        else $error("qualified request not taken");

    a_timer_defer: assert property (instr_end_i && timer_defer |=> !psw_swap_o)
        else $error("acceptance not deferred after timer reference");

    a_mask_or: assert property (mask_update_i && mask_or_i
        |=> (mask_o & $past(mask_word_i)) == $past(mask_word_i))
        else $error("OR mask update lost a level");

    a_mask_and: assert property (mask_update_i && !mask_or_i && !mask_cancel_i
        |=> (mask_o & ~$past(mask_word_i)) == '0)
        else $error("AND mask update kept a level");

    a_cancel_clear: assert property (mask_update_i && mask_cancel_i && rise == '0
        |=> (pending_o & $past(mask_word_i)) == '0)
        else $error("cancel left a tagged request pending");

    a_edge_sets: assert property (|rise |=> (pending_o & $past(rise)) == $past(rise))
        else $error("detected edge did not set latch");

endmodule

`default_nettype wire

// ==== testbench/acq_device_model.sv ====
// Model of the external acquisition device: request pulses and the acknowledge answer
`timescale 1ns/100ps
`default_nettype none

module acq_device_model (
    input wire logic core_clk_i,
    input wire logic strobe_i,
    input wire logic [4:0] code_i,
    input wire logic [15:0] ack_delay_i,
    output logic [31:0] request_o,
    output logic ack_o,
    output logic [7:0] desc_o
);
    // Idle levels at time zero
    initial begin
        request_o = 32'h0;
        ack_o = 1'h0;
        desc_o = 8'h0;
    end

    // bounded pulse length
    // Callers keep len between 100 and 200 cycles, i.e. 0.5 to 1 us
    task automatic pulse(input logic [31:0] lines, input int len);
        @(posedge core_clk_i);
        request_o <= request_o | lines;
        repeat (len) @(posedge core_clk_i);
        request_o <= request_o & ~lines;
    endtask

    // interlocked answer, no repeats
    // Byte churns while idle so a stale capture never matches
    always begin
        @(posedge core_clk_i);
        if (!strobe_i) begin
            desc_o <= desc_o + 8'h3b;
        end else begin
            desc_o <= {3'h5, code_i};
            repeat (ack_delay_i) @(posedge core_clk_i);
            ack_o <= 1'h1;
            while (strobe_i) @(posedge core_clk_i);
            repeat (4) @(posedge core_clk_i);
            ack_o <= 1'h0;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/tb_priority_interrupt_request_accept.sv ====
// Self-checking bench for the priority request logic
`timescale 1ns/100ps
`default_nettype none

module tb_priority_interrupt_request_accept;
    import prio_irq_pkg::*;

    typedef struct {
        logic o;
        logic c;
        logic [31:0] w;
        logic [31:0] m;
        logic [31:0] p;
    } row_s;

    logic core_clk_i = 1'h0, rst_i = 1'h1, ack, strobe, seq_stop, swap, fetch, bg_grant, stop_at_swap;
    logic instr_end = 1'h0, timer_ref = 1'h0, timer_present = 1'h0, bg_req = 1'h0, level_exit = 1'h0;
    logic mask_update = 1'h0, mask_or = 1'h0, mask_cancel = 1'h0, timer_load = 1'h0;
    logic [31:0] req, mask_word = 32'h0, load_word = 32'h0, pending, active, mask, timer_word;
    logic [15:0] ack_delay = 16'ha;
    logic [7:0] desc, desc_q;
    logic [4:0] code, code_at_swap;
    int mismatches = 0, n_compared = 0, cyc = 0, s0 = 0;
    int t_swap = 0, t_strobe = 0, t_sfall = 0, t_ack = 0, t_fetch = 0, n_swap = 0, n_fetch = 0, n_bg = 0;
    row_s rows [4] = '{
        '{1'h1, 1'h0, 32'h0000_00ff, 32'h0000_00ff, 32'h0000_0050},
        '{1'h0, 1'h0, 32'h0000_000f, 32'h0000_000f, 32'h0000_0050},
        '{1'h0, 1'h1, 32'h0000_0010, 32'h0000_000f, 32'h0000_0040},
        '{1'h1, 1'h1, 32'h0000_0f40, 32'h0000_0f4f, 32'h0000_0000}};

    always #2.5 core_clk_i = ~core_clk_i;

    priority_interrupt_request_accept i_priority_interrupt_request_accept (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .request_i(req), .ack_i(ack), .desc_i(desc),
        .instr_end_i(instr_end), .timer_ref_i(timer_ref), .timer_present_i(timer_present),
        .bg_req_i(bg_req), .level_exit_i(level_exit), .mask_update_i(mask_update), .mask_or_i(mask_or),
        .mask_cancel_i(mask_cancel), .mask_word_i(mask_word), .timer_load_i(timer_load),
        .timer_load_word_i(load_word), .grant_code_o(code), .strobe_o(strobe), .seq_stop_o(seq_stop),
        .psw_swap_o(swap), .fetch_o(fetch), .bg_grant_o(bg_grant), .desc_o(desc_q), .pending_o(pending),
        .active_o(active), .mask_o(mask), .timer_word_o(timer_word));

    acq_device_model i_acq_device_model (.core_clk_i(core_clk_i), .strobe_i(strobe), .code_i(code),
        .ack_delay_i(ack_delay), .request_o(req), .ack_o(ack), .desc_o(desc));

    // Event times and counts, read back by the tests
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (swap) begin
            t_swap <= cyc;
            n_swap <= n_swap + 1;
            code_at_swap <= code;
            stop_at_swap <= seq_stop;
        end
        if ($rose(strobe)) t_strobe <= cyc;
        if ($fell(strobe)) t_sfall <= cyc;
        if ($rose(ack)) t_ack <= cyc;
        if (fetch) begin
            t_fetch <= cyc;
            n_fetch <= n_fetch + 1;
        end
        if (bg_grant) n_bg <= n_bg + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One instruction boundary, optionally touching the timer word
    task automatic boundary(input logic with_ref);
        @(posedge core_clk_i);
        instr_end <= 1'h1;
        timer_ref <= with_ref;
        @(posedge core_clk_i);
        instr_end <= 1'h0;
        timer_ref <= 1'h0;
    endtask

    task automatic exit_level();
        @(posedge core_clk_i);
        level_exit <= 1'h1;
        @(posedge core_clk_i);
        level_exit <= 1'h0;
    endtask

    task automatic mask_op(input logic o, input logic c, input logic [31:0] w);
        @(posedge core_clk_i);
        mask_update <= 1'h1;
        mask_or <= o;
        mask_cancel <= c;
        mask_word <= w;
        @(posedge core_clk_i);
        mask_update <= 1'h0;
        @(posedge core_clk_i);
        #1;
    endtask

    // Full grant with the partner answering after dly cycles; waits for the fetch
    task automatic serve(input logic [4:0] lvl, input logic [15:0] dly);
        int n;
        int f0;
        ack_delay = dly;
        f0 = n_fetch;
        n = 0;
        boundary(1'h0);
        while (n_fetch == f0 && n < 3000) begin
            @(posedge core_clk_i);
            n++;
        end
        #1;
        check(code_at_swap, lvl, "code at swap");
        check(stop_at_swap, 1'h1, "sequencing stop");
        check(code, lvl, "winning level");
        check(t_strobe - t_swap, CODE_SETUP_CYC, "code to strobe");
        check(desc_q, {3'h5, lvl}, "descriptor");
        check(pending[lvl], 1'h0, "latch cleared");
        check(active[lvl], 1'h1, "level active");
        check(t_sfall - t_ack inside {[500:600]}, 1'h1, "strobe hold");
        if (dly < 16'hc8) begin
            check(t_fetch - t_swap inside {[1000:1002]}, 1'h1, "prompt fetch");
        end else begin
            check(t_fetch - t_ack inside {[600:606]}, 1'h1, "late fetch");
        end
        done("grant");
    endtask

    initial begin
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'h0;
        i_acq_device_model.pulse(32'h50, 100);
        // Mask update modes, one row each
        foreach (rows[i]) begin
            mask_op(rows[i].o, rows[i].c, rows[i].w);
            check(mask, rows[i].m, "mask");
            check(pending, rows[i].p, "pending after update");
        end
        done("mask table");
        // Reset in mid-run clears latches, mask and timer
        i_acq_device_model.pulse(32'h80, 100);
        timer_load <= 1'h1;
        load_word <= 32'h1234;
        @(posedge core_clk_i);
        timer_load <= 1'h0;
        #1;
        check(pending, 32'h80, "latched");
        @(posedge core_clk_i);
        rst_i <= 1'h1;
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'h0;
        #1;
        check(pending, 32'h0, "pending reset");
        check(mask, 32'h0, "mask reset");
        check(timer_word, 32'h0, "timer reset");
        check(active, 32'h0, "active reset");
        done("reset");
        mask_op(1'h1, 1'h0, 32'hffff_ffff);
        i_acq_device_model.pulse(32'h28, 100);
        #1;
        check(pending, 32'h28, "two latched");
        i_acq_device_model.pulse(32'h08, 100);
        serve(5'h3, 16'ha);
        check(pending, 32'h20, "repeat absorbed");
        // Lower level stays pending behind the active one
        s0 = n_swap;
        boundary(1'h0);
        repeat (4) @(posedge core_clk_i);
        check(n_swap, s0, "blocked by active");
        i_acq_device_model.pulse(32'h02, 100);
        serve(5'h1, 16'h190);
        check(active, 32'h0a, "nested levels");
        exit_level();
        exit_level();
        serve(5'h5, 16'ha);
        i_acq_device_model.pulse(32'h20, 100);
        #1;
        check(pending, 32'h20, "second request");
        mask_op(1'h1, 1'h1, 32'hffff_ffff);
        check(pending, 32'h0, "cancelled");
        exit_level();
        done("nesting");
        // Timer word reference defers acceptance
        i_acq_device_model.pulse(32'h04, 100);
        timer_present <= 1'h1;
        s0 = n_swap;
        boundary(1'h1);
        repeat (4) @(posedge core_clk_i);
        check(n_swap, s0, "deferred");
        serve(5'h2, 16'ha);
        exit_level();
        // Background request taken when no level is active
        bg_req <= 1'h1;
        s0 = n_bg;
        boundary(1'h0);
        repeat (3) @(posedge core_clk_i);
        check(n_bg, s0 + 1, "background taken");
        bg_req <= 1'h0;
        done("defer and background");
        @(posedge core_clk_i);
        timer_load <= 1'h1;
        load_word <= 32'h5;
        @(posedge core_clk_i);
        timer_load <= 1'h0;
        repeat (2605) @(posedge core_clk_i);
        #1;
        check(timer_word, 32'h4, "timer step");
        done("timer");
        close_out();
    end

    // Watchdog sized well above the expected run of about 7400 cycles
    initial begin
        repeat (40000) @(posedge core_clk_i);
        mismatches++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        close_out();
    end
endmodule
`default_nettype wire
